// ### core/cmr_pkg.sv
// cmr_pkg: constants for the message RAM layout and transmit object block.
// assumes a 32-bit APB register port and one 100 MHz system clock.
package cmr_pkg;
  // register byte offsets
  localparam logic [11:0] CMR_CAN_CTRL  = 12'h000; // can_control_reg
  localparam logic [11:0] CMR_TEF_CTRL  = 12'h004;
  localparam logic [11:0] CMR_TXQ_CTRL  = 12'h008; // tx_queue_control_reg
  localparam logic [11:0] CMR_TX_GO     = 12'h00c;
  localparam logic [11:0] CMR_STATUS    = 12'h010;
  localparam logic [11:0] CMR_TX_WORD0  = 12'h020;
  localparam logic [11:0] CMR_TX_WORD1  = 12'h024;
  localparam logic [11:0] CMR_TX_DATA   = 12'h040; // 16 words to 0x07c
  localparam logic [11:0] CMR_FIFO_CTRL = 12'h080; // fifo m at +4*m
  localparam logic [11:0] CMR_REG_START = 12'h100; // region k at +4*k
  localparam logic [11:0] CMR_REG_END   = 12'h184;

  // can_control_reg fields
  localparam int CMR_RUN_BIT    = 0; // 0 = configuration mode
  localparam int CMR_CLASSIC    = 1;
  localparam int CMR_GW_BIT     = 2; // gateway_error_flag_mode
  localparam int CMR_TXQ_EN_BIT = 3; // tx_queue_reserve_en
  localparam int CMR_TEF_EN_BIT = 4;
  // shared control fields: object_count_field, payload_size_field
  localparam int CMR_CNT_LSB    = 0;
  localparam int CMR_PL_LSB     = 5;
  localparam int CMR_TEF_TS_BIT = 5; // tx_event_stamp_en
  localparam int CMR_DIR_BIT    = 8; // fifo_direction_tx
  localparam int CMR_RXTS_BIT   = 9; // rx_stamp_en
  // transmit object word layout
  localparam int CMR_EID_LSB    = 11;
  localparam int CMR_SEQ_LSB    = 9;
  localparam int CMR_ESI_BIT    = 8;
  localparam int CMR_FDF_BIT    = 7;
  localparam int CMR_BRS_BIT    = 6;
  localparam int CMR_RTR_BIT    = 5;
  localparam int CMR_IDE_BIT    = 4;

  // sizes in bytes, fifo and region counts, control reset value
  localparam logic [6:0]  CMR_HDR_BYTES = 7'h08;
  localparam logic [6:0]  CMR_TS_BYTES  = 7'h04;
  localparam int          CMR_RAM_BYTES = 2048;
  localparam int          CMR_FIFOS     = 31;
  localparam int          CMR_REGIONS   = 33; // event fifo, queue, 31 fifos
  localparam logic [31:0] CMR_CTRL_RST  = 32'h0000_0000;

  // transmit sequencer states, gray along the path except the HDR to SEQ skip for empty frames
  typedef enum logic [1:0] {
    CMR_IDLE = 2'b00,
    CMR_HDR  = 2'b01,
    CMR_DATA = 2'b11,
    CMR_SEQ  = 2'b10
  } cmr_tx_st_t;
endpackage : cmr_pkg

// ### core/cmr_core.sv
// cmr_core: message RAM layout engine and transmit object sequencer.
// assumes an APB master on i_clk, a frame engine on the same clock taking
// header and bytes by valid/ready, and an asynchronous error-passive pin.
//
// Operation
// - queue gets RAM only when its reserve enable bit is set.
// - queue depth from count field; one payload size for all objects.
// - fifos 1 to 31 with direction bit set act as transmit fifos.
// - fifos with direction bit clear act as receive fifos.
// - receive fifo with stamp enable attaches timestamp to stored messages.
// - event fifo object is 8 bytes, plus 4 with stamp enable.
// - unused event fifo or queue takes zero; queue object 8 plus payload.
// - fifo object 8 plus payload, plus 4 if receive and stamped.
// - regions laid out event fifo, queue, then fifo 1 upward.
// - message RAM capacity is 2048 bytes in total; the layout total is shown in status, never checked against it.
// - IDE clear sends base frame, set sends extended frame.
// - RTR honoured only in classic frames, requesting remote transmission.
// - FDF selects FD frame; classic-only mode ignores it.
// - BRS set sends FD data phase at data rate, else nominal.
// - FD ESI recessive when error passive, dominant when error active.
// - gateway mode clear: object ESI ignored, own error state only.
// - gateway mode set: ESI is OR of error passive and object bit.
// - sequence tag never sent; copied to the event fifo entry.
// - send DLC byte count, byte 0 first, ascending.
// - word 0 holds extension in 28..11 and base id in 10..0.
// - word 1 holds tag, ESI, FDF, BRS, RTR, IDE, DLC.
`timescale 1ns/1ps
`default_nettype none
module cmr_core
  import cmr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // error state pin from the fault confinement logic
  input  wire logic        i_err_passive,
  // frame engine side
  input  wire logic        i_tx_ready,
  output logic             o_tx_hdr_valid,
  output logic      [28:0] o_tx_id,
  output logic             o_tx_ide,
  output logic             o_tx_rtr,
  output logic             o_tx_fdf,
  output logic             o_tx_brs,
  output logic             o_tx_esi,
  output logic      [3:0]  o_tx_dlc,
  output logic             o_tx_byte_valid,
  output logic      [7:0]  o_tx_byte,
  output logic             o_tx_byte_last,
  output logic             o_seq_valid,
  output logic      [22:0] o_seq_tag,
  // receive store notification
  input  wire logic        i_rx_store,
  input  wire logic [4:0]  i_rx_fifo,
  output logic             o_rx_attach_stamp
);

  // whole module state
  typedef struct packed {
    logic                   run;
    logic                   classic;
    logic                   gw;
    logic                   txq_en;
    logic                   tef_en;
    logic [5:0]             tef_cfg;
    logic [7:0]             txq_cfg;
    logic [31:1][9:0]       fifo_cfg;
    logic [32:0][16:0]      start;
    logic [16:0]            total;
    logic [5:0]             walk;
    logic [16:0]            sum;
    logic [31:0]            w0;
    logic [31:0]            w1;
    logic [15:0][31:0]      data;
    cmr_tx_st_t             st;
    logic [6:0]             bidx;
    logic [6:0]             blen;
    logic                   ep_s1;
    logic                   ep_s2;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   hdr_valid;
    logic [28:0]            id;
    logic                   ide;
    logic                   rtr;
    logic                   fdf;
    logic                   brs;
    logic                   esi;
    logic [3:0]             dlc;
    logic                   byte_valid;
    logic [7:0]             byte_q;
    logic                   byte_last;
    logic                   seq_valid;
    logic [22:0]            seq;
    logic                   rx_stamp;
  } cmr_st_t;

  cmr_st_t r_reg;
  cmr_st_t r_next;

  // payload code to bytes: 8,12,16,20,24,32,48,64
  function automatic logic [6:0] pl_bytes(input logic [2:0] code);
    logic [6:0] b;
    b = 7'h08;
    unique case (code)
      3'h0: b = 7'h08;
      3'h1: b = 7'h0c;
      3'h2: b = 7'h10;
      3'h3: b = 7'h14;
      3'h4: b = 7'h18;
      3'h5: b = 7'h20;
      3'h6: b = 7'h30;
      3'h7: b = 7'h40;
    endcase
    return b;
  endfunction : pl_bytes

  // dlc to byte count; classic frames saturate at eight
  function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc,
                                           input logic       fd);
    logic [6:0] b;
    b = {3'h0, dlc};
    if (dlc > 4'h8) begin
      b = fd ? pl_bytes(3'(dlc - 4'h8)) : 7'h08;
    end
    return b;
  endfunction : dlc_bytes

  // region size: objects times object size, zero when unused
  function automatic logic [16:0] reg_size(input logic       en,
                                           input logic [4:0] cnt,
                                           input logic [6:0] obj);
    logic [12:0] prod;
    prod = 13'({1'b0, cnt} + 6'h01) * 13'(obj);
    return en ? 17'(prod) : 17'h0_0000;
  endfunction : reg_size

  logic        apb_setup;
  logic        apb_wr;
  logic        tx_fire;
  logic        byte_take;
  logic [16:0] walk_size;
  logic [9:0]  wf;
  logic [4:0]  fm;
  logic [6:0]  widx;
  logic [3:0]  didx;
  logic        fd_eff;
  logic        rtr_eff;
  logic [6:0]  nidx;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr    = i_psel & i_penable & r_reg.pready & i_pwrite;
  assign tx_fire   = apb_wr & (i_paddr == CMR_TX_GO)
                   & (r_reg.st == CMR_IDLE) & r_reg.run;
  assign byte_take = (r_reg.st == CMR_DATA) & r_reg.byte_valid & i_tx_ready;
  assign fd_eff    = r_reg.w1[CMR_FDF_BIT] & ~r_reg.classic;
  assign rtr_eff   = r_reg.w1[CMR_RTR_BIT] & ~fd_eff;
  assign nidx      = r_reg.bidx + 7'h01;
  assign fm        = 5'(r_reg.walk - 6'd1); // walk 2 is fifo 1
  assign widx      = 7'((i_paddr - CMR_FIFO_CTRL) >> 2);

  // size of the region the walker is on, in layout order
  always_comb begin
    wf = r_reg.fifo_cfg[(fm == 5'h00) ? 5'h01 : fm];
    if (r_reg.walk == 6'd0) begin
      walk_size = reg_size(r_reg.tef_en, r_reg.tef_cfg[4:0],
        CMR_HDR_BYTES + (r_reg.tef_cfg[CMR_TEF_TS_BIT] ?
        CMR_TS_BYTES : 7'h00));
    end else if (r_reg.walk == 6'd1) begin
      walk_size = reg_size(r_reg.txq_en, r_reg.txq_cfg[4:0],
        CMR_HDR_BYTES + pl_bytes(r_reg.txq_cfg[7:5]));
    end else begin
      // stamp bytes only on receive fifos
      walk_size = reg_size(1'b1, wf[4:0], CMR_HDR_BYTES
        + pl_bytes(wf[7:5])
        + ((!wf[CMR_DIR_BIT] && wf[CMR_RXTS_BIT]) ?
           CMR_TS_BYTES : 7'h00));
    end
  end

  // next-state logic for the whole block
  always_comb begin
    r_next = r_reg;
    didx   = 4'(i_paddr[5:2]);
    // error pin: two flops before use
    r_next.ep_s1 = i_err_passive;
    r_next.ep_s2 = r_reg.ep_s1;

    // apb: answer in the access cycle, zero wait states
    r_next.pready  = apb_setup;
    r_next.pslverr = 1'b0;
    r_next.prdata  = 32'h0000_0000;
    if (apb_setup) begin
      if (i_paddr[1:0] != 2'b00) begin
        r_next.pslverr = 1'b1;
      end else if (i_paddr == CMR_CAN_CTRL) begin
        r_next.prdata = {27'h0, r_reg.tef_en, r_reg.txq_en, r_reg.gw,
                         r_reg.classic, r_reg.run};
      end else if (i_paddr == CMR_TEF_CTRL) begin
        r_next.prdata = {26'h0, r_reg.tef_cfg};
      end else if (i_paddr == CMR_TXQ_CTRL) begin
        r_next.prdata = {24'h0, r_reg.txq_cfg};
      end else if (i_paddr == CMR_TX_GO) begin
        r_next.prdata = 32'h0000_0000;
      end else if (i_paddr == CMR_STATUS) begin
        // total usage shown, never enforced against capacity
        r_next.prdata = {r_reg.total, 13'h0000, r_reg.ep_s2,
                         r_reg.st != CMR_IDLE};
      end else if (i_paddr == CMR_TX_WORD0) begin
        r_next.prdata = r_reg.w0;
      end else if (i_paddr == CMR_TX_WORD1) begin
        r_next.prdata = r_reg.w1;
      end else if (i_paddr >= CMR_TX_DATA && i_paddr < CMR_FIFO_CTRL) begin
        r_next.prdata = r_reg.data[didx];
      end else if (i_paddr > CMR_FIFO_CTRL && i_paddr < CMR_REG_START) begin
        r_next.prdata = {22'h0, r_reg.fifo_cfg[5'(widx)]};
      end else if (i_paddr >= CMR_REG_START && i_paddr < CMR_REG_END) begin
        r_next.prdata = {15'h0,
          r_reg.start[6'((i_paddr - CMR_REG_START) >> 2)]};
      end else begin
        r_next.pslverr = 1'b1; // unmapped
      end
    end

    // register writes; layout fields only while configuring
    if (apb_wr) begin
      if (i_paddr == CMR_CAN_CTRL) begin
        r_next.run = i_pwdata[CMR_RUN_BIT];
        if (!r_reg.run) begin
          r_next.classic = i_pwdata[CMR_CLASSIC];
          r_next.gw      = i_pwdata[CMR_GW_BIT];
          r_next.txq_en  = i_pwdata[CMR_TXQ_EN_BIT];
          r_next.tef_en  = i_pwdata[CMR_TEF_EN_BIT];
        end
      end else if (i_paddr == CMR_TEF_CTRL && !r_reg.run) begin
        r_next.tef_cfg = i_pwdata[5:0];
      end else if (i_paddr == CMR_TXQ_CTRL && !r_reg.run) begin
        r_next.txq_cfg = i_pwdata[7:0];
      end else if (i_paddr == CMR_TX_WORD0 && r_reg.st == CMR_IDLE) begin
        r_next.w0 = i_pwdata;
      end else if (i_paddr == CMR_TX_WORD1 && r_reg.st == CMR_IDLE) begin
        r_next.w1 = i_pwdata;
      end else if (i_paddr >= CMR_TX_DATA && i_paddr < CMR_FIFO_CTRL
                   && r_reg.st == CMR_IDLE) begin
        r_next.data[didx] = i_pwdata;
      end else if (i_paddr > CMR_FIFO_CTRL && i_paddr < CMR_REG_START
                   && !r_reg.run) begin
        r_next.fifo_cfg[5'(widx)] = i_pwdata[9:0];
      end
    end

    // layout walker: event fifo, queue, fifo 1..31, one region a cycle;
    // frozen outside config so live pointers never move under traffic
    if (!r_reg.run) begin
      r_next.start[r_reg.walk] = r_reg.sum;
      if (r_reg.walk == 6'(CMR_REGIONS - 1)) begin
        r_next.total = r_reg.sum + walk_size;
        r_next.walk  = 6'd0;
        r_next.sum   = 17'h0_0000;
      end else begin
        r_next.walk = r_reg.walk + 6'd1;
        r_next.sum  = r_reg.sum + walk_size;
      end
    end else begin
      r_next.walk = 6'd0;
      r_next.sum  = 17'h0_0000;
    end

    // receive store: flag whether a timestamp is appended
    r_next.rx_stamp = i_rx_store && (i_rx_fifo != 5'h00)
      && !r_reg.fifo_cfg[i_rx_fifo][CMR_DIR_BIT]
      && r_reg.fifo_cfg[i_rx_fifo][CMR_RXTS_BIT];

    // transmit sequencer
    r_next.seq_valid = 1'b0;
    unique case (r_reg.st)
      CMR_IDLE: begin
        if (tx_fire) begin
          r_next.st        = CMR_HDR;
          r_next.hdr_valid = 1'b1;
          r_next.ide = r_reg.w1[CMR_IDE_BIT];
          // base id in low bits, extension above it
          r_next.id  = r_reg.w1[CMR_IDE_BIT] ? r_reg.w0[28:0]
                     : {18'h0_0000, r_reg.w0[10:0]};
          r_next.fdf = fd_eff;
          r_next.rtr = rtr_eff;
          r_next.brs = r_reg.w1[CMR_BRS_BIT] & fd_eff;
          // own state, or-ed with object bit in gateway mode
          r_next.esi = r_reg.ep_s2
            | (r_reg.gw & r_reg.w1[CMR_ESI_BIT]);
          r_next.dlc = r_reg.w1[3:0];
          r_next.blen = rtr_eff ? 7'h00
                      : dlc_bytes(r_reg.w1[3:0], fd_eff);
          r_next.bidx = 7'h00;
        end
      end
      CMR_HDR: begin
        if (i_tx_ready) begin
          r_next.hdr_valid = 1'b0;
          if (r_reg.blen == 7'h00) begin
            r_next.st        = CMR_SEQ;
            r_next.seq_valid = 1'b1;
            r_next.seq       = r_reg.w1[31:CMR_SEQ_LSB];
          end else begin
            r_next.st         = CMR_DATA;
            r_next.byte_valid = 1'b1;
            r_next.byte_q     = r_reg.data[0][7:0];
            r_next.byte_last  = r_reg.blen == 7'h01;
          end
        end
      end
      CMR_DATA: begin
        if (byte_take) begin
          if (r_reg.byte_last) begin
            r_next.byte_valid = 1'b0;
            r_next.byte_last  = 1'b0;
            r_next.st         = CMR_SEQ;
            r_next.seq_valid  = 1'b1;
            r_next.seq        = r_reg.w1[31:CMR_SEQ_LSB];
          end else begin
            // ascending byte order, low lane of each word first
            r_next.bidx      = nidx;
            r_next.byte_q    = r_reg.data[nidx[5:2]][nidx[1:0]*8 +: 8];
            r_next.byte_last = (nidx + 7'h01) == r_reg.blen;
          end
        end
      end
      CMR_SEQ: begin
        r_next.st = CMR_IDLE;
      end
    endcase
  end

  // state register; clock enable freezes everything
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign o_prdata          = r_reg.prdata;
  assign o_pready          = r_reg.pready;
  assign o_pslverr         = r_reg.pslverr;
  assign o_tx_hdr_valid    = r_reg.hdr_valid;
  assign o_tx_id           = r_reg.id;
  assign o_tx_ide          = r_reg.ide;
  assign o_tx_rtr          = r_reg.rtr;
  assign o_tx_fdf          = r_reg.fdf;
  assign o_tx_brs          = r_reg.brs;
  assign o_tx_esi          = r_reg.esi;
  assign o_tx_dlc          = r_reg.dlc;
  assign o_tx_byte_valid   = r_reg.byte_valid;
  assign o_tx_byte         = r_reg.byte_q;
  assign o_tx_byte_last    = r_reg.byte_last;
  assign o_seq_valid       = r_reg.seq_valid;
  assign o_seq_tag         = r_reg.seq;
  assign o_rx_attach_stamp = r_reg.rx_stamp;

  // elaboration check: capacity must cover at least one object and the fifo count must be 31
  if (CMR_RAM_BYTES < 8 || CMR_FIFOS != 31) begin : g_chk
    $error("cmr_core: unsupported RAM or fifo count");
  end

  // assertions
  property p_classic_fdf;
    @(posedge i_clk) disable iff (!i_rst_b)
    (o_tx_hdr_valid && r_reg.classic) |-> !o_tx_fdf;
  endproperty
  a_classic_fdf: assert property (p_classic_fdf)
    else $error("fd frame sent in classic mode");

  property p_rtr_classic;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_tx_hdr_valid |-> !(o_tx_rtr && o_tx_fdf);
  endproperty
  a_rtr_classic: assert property (p_rtr_classic)
    else $error("remote request on fd frame");

  property p_brs_fd;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_tx_brs |-> o_tx_fdf;
  endproperty
  a_brs_fd: assert property (p_brs_fd)
    else $error("rate switch on classic frame");

  property p_esi;
    @(posedge i_clk) disable iff (!i_rst_b)
    tx_fire && i_ce |=> o_tx_hdr_valid && o_tx_esi ==
      ($past(r_reg.ep_s2) | ($past(r_reg.gw) & $past(r_reg.w1[8])));
  endproperty
  a_esi: assert property (p_esi)
    else $error("esi not from error state and gateway mode");

  property p_byte_order;
    @(posedge i_clk) disable iff (!i_rst_b)
    (byte_take && i_ce && !r_reg.byte_last) |=>
      r_reg.bidx == $past(r_reg.bidx) + 7'h01 && o_tx_byte_valid;
  endproperty
  a_byte_order: assert property (p_byte_order)
    else $error("payload bytes out of order");

  property p_seq;
    @(posedge i_clk) disable iff (!i_rst_b)
    o_seq_valid |-> o_seq_tag == r_reg.w1[31:9] && !o_tx_byte_valid
      ##1 !o_seq_valid;
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequence tag pulse wrong");

  property p_tef_zero;
    @(posedge i_clk) disable iff (!i_rst_b)
    (!r_reg.run && r_reg.walk == 6'd1 && !r_reg.tef_en
      && $past(!r_reg.tef_en)) |-> r_reg.sum == 17'h0_0000;
  endproperty
  a_tef_zero: assert property (p_tef_zero)
    else $error("unused event fifo takes space");

  property p_frozen;
    @(posedge i_clk) disable iff (!i_rst_b)
    (r_reg.run && $past(r_reg.run)) |-> $stable(r_reg.start);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("layout moved outside configuration");

  property p_rx_stamp;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rx_store && i_rx_fifo != 5'h00
      && r_reg.fifo_cfg[i_rx_fifo][9:8] == 2'b10) |=> o_rx_attach_stamp;
  endproperty
  a_rx_stamp: assert property (p_rx_stamp)
    else $error("receive stamp not attached");

endmodule : cmr_core
`default_nettype wire

// ### tb/cmr_sink.sv
// cmr_sink: frame engine stand-in on the transmit stream side.
// assumes the block's valid/ready handshake on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cmr_sink (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_slow,
  input  wire logic        i_clear,
  input  wire logic        i_byte_valid,
  input  wire logic [7:0]  i_byte,
  input  wire logic        i_seq_valid,
  input  wire logic [22:0] i_seq_tag,
  output logic             o_ready
);
  logic [7:0]  bytes [64];
  int          n;
  int          nseq;
  logic [22:0] tag;
  logic        tick;
  // slow mode drops ready every other cycle, stalling header and bytes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready <= 1'b0;
      tick    <= 1'b0;
      n       <= 0;
      nseq    <= 0;
    end else begin
      tick    <= ~tick;
      o_ready <= ~i_slow | tick;
      if (i_clear) begin
        n    <= 0;
        nseq <= 0;
      end else begin
        if (o_ready && i_byte_valid) begin
          bytes[n[5:0]] <= i_byte;
          n             <= n + 1;
        end
        if (i_seq_valid) begin
          nseq <= nseq + 1;
          tag  <= i_seq_tag; // tag seen only here, never in the bytes
        end
      end
    end
  end
endmodule : cmr_sink
`default_nettype wire

// ### tb/testbench.sv
// testbench: drives the message RAM block over APB and checks its outputs.
// assumes cmr_core with the frame engine modelled by cmr_sink.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cmr_pkg::*;
  logic clk, rst_b, psel, pen, pwr, errp, rdy, rxs, slow, clr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, att, e, bv, sv, ide, rtr, fdf, brs, esi;
  logic [28:0] id;
  logic [7:0]  b;
  logic [22:0] tag;
  logic [4:0]  rxf;
  logic [3:0]  dlc;
  logic        hv, bl;
  int err_count, num_checks;
  cmr_core dut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_err_passive(errp), .i_tx_ready(rdy), .o_tx_hdr_valid(hv),
    .o_tx_id(id), .o_tx_ide(ide), .o_tx_rtr(rtr), .o_tx_fdf(fdf),
    .o_tx_brs(brs), .o_tx_esi(esi), .o_tx_dlc(dlc), .o_tx_byte_valid(bv),
    .o_tx_byte(b), .o_tx_byte_last(bl), .o_seq_valid(sv), .o_seq_tag(tag),
    .i_rx_store(rxs), .i_rx_fifo(rxf), .o_rx_attach_stamp(att));
  cmr_sink sink (.i_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_clear(clr),
    .i_byte_valid(bv), .i_byte(b), .i_seq_valid(sv), .i_seq_tag(tag),
    .o_ready(rdy));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [63:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
    if (k >= 50) begin
      err_count++;
      complete_run();
    end
  endtask : apb
  // reset value, layout sums and region order
  task automatic t_layout();
    apb(0, CMR_CAN_CTRL, 0);
    chk("ctrl reset", q, CMR_CTRL_RST);
    apb(0, 12'h080, 0);
    chk("unmapped err", e, 1'b1);
    apb(1, CMR_CAN_CTRL, 32'h10);
    apb(1, CMR_TEF_CTRL, 32'h21);
    apb(1, CMR_TXQ_CTRL, 32'ha0);
    apb(1, 12'h084, 32'h201);
    apb(1, 12'h088, 32'h300);
    repeat (70) @(posedge clk);
    apb(0, 12'h108, 0);
    chk("start fifo1 no queue", q, 32'd24);
    apb(1, CMR_CAN_CTRL, 32'h18);
    repeat (70) @(posedge clk);
    apb(0, 12'h108, 0);
    chk("start fifo1", q, 32'd64);
    apb(0, 12'h10c, 0);
    chk("start fifo2", q, 32'd104);
    apb(0, 12'h110, 0);
    chk("start fifo3", q, 32'd120);
    apb(0, 12'h180, 0);
    chk("start fifo31", q, 32'd568);
    apb(0, CMR_STATUS, 0);
    chk("total bytes", q[31:15], 17'd584);
  endtask : t_layout
  // stamp flag follows direction and stamp enable of the stored fifo
  task automatic t_rx_stamp(input logic [4:0] f, input logic ex);
    rxf <= f;
    rxs <= 1'b1;
    @(posedge clk);
    rxs <= 1'b0;
    @(posedge clk);
    chk("attach stamp", att, ex);
  endtask : t_rx_stamp
  // one frame through the sink, then header, bytes and tag compared
  task automatic t_send(input logic [31:0] w0, w1, input logic sl,
                        input logic [28:0] xid, input logic [4:0] fl,
                        input int len);
    int k;
    apb(1, CMR_TX_WORD0, w0);
    apb(1, CMR_TX_WORD1, w1);
    slow <= sl;
    clr  <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    apb(1, CMR_TX_GO, 0);
    k = 0;
    while (sink.nseq == 0 && k < 300) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    chk("frame done", k < 300, 1'b1);
    chk("id", id, xid);
    chk("ide rtr fdf brs esi", {ide, rtr, fdf, brs, esi}, fl);
    chk("byte count", sink.n, len);
    for (k = 0; k < len; k++) chk("byte", sink.bytes[k], 8'h10 + k);
    chk("seq tag", sink.tag, w1[31:9]);
    chk("dlc", dlc, w1[3:0]);
    chk("hdr valid low", hv, 1'b0);
    chk("byte last low", bl, 1'b0);
  endtask : t_send
  initial begin
    err_count = 0;
    num_checks = 0;
    {psel, pen, pwr, errp, rxs, slow, clr} = '0;
    paddr = '0;
    pwdata = '0;
    rxf = '0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_layout();
    t_rx_stamp(5'd1, 1'b1);
    t_rx_stamp(5'd2, 1'b0);
    t_rx_stamp(5'd3, 1'b0);
    for (int i = 0; i < 16; i++)
      apb(1, CMR_TX_DATA + 12'(4 * i), {8'h13, 8'h12, 8'h11, 8'h10}
          + {4{8'(4 * i)}});
    apb(1, CMR_CAN_CTRL, 32'h19);
    t_send(32'h1234_5678, {23'h05a5a5, 9'h1d9}, 1'b1, 29'h1234_5678,
           5'b10110, 12);
    t_send(32'h1fff_f7ab, {23'h000001, 9'h022}, 1'b0, 29'h0000_07ab,
           5'b01000, 0);
    apb(1, CMR_CAN_CTRL, 32'h18);
    apb(1, CMR_CAN_CTRL, 32'h1f);
    t_send(32'h0000_0123, {23'h7fffff, 9'h1ca}, 1'b1, 29'h0000_0123,
           5'b00001, 8);
    errp <= 1'b1;
    repeat (4) @(posedge clk);
    t_send(32'h0000_0321, {23'h000002, 9'h004}, 1'b0, 29'h0000_0321,
           5'b00001, 4);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
